// [core/odrd_regs.svh]
`ifndef ODRD_REGS_SVH
`define ODRD_REGS_SVH

// format 2 descriptor byte values
`define ODRD_F2_A      8'h5b
`define ODRD_F2_B      8'hab
`define ODRD_F2_C      8'hbb
`define ODRD_F2_D      8'hcb
`define ODRD_F2_E      8'hdb

// descriptor field positions
`define ODRD_REG_LSB   0
`define ODRD_MODE_LSB  4
`define ODRD_NIB_W     4

// special register numbers
`define ODRD_R_FP      5'h09
`define ODRD_R_AP      5'h0a
`define ODRD_R_PSW     5'h0b
`define ODRD_R_SP      5'h0c
`define ODRD_R_PCBP    5'h0d
`define ODRD_R_ISP     5'h0e
`define ODRD_R_PC      5'h0f
`define ODRD_R_PRIV_LO 5'h18
`define ODRD_REG_SEL_PC 4'hf

// format 1 mode numbers
`define ODRD_M_REG     4'h4
`define ODRD_M_REGDEF  4'h5
`define ODRD_M_FPSO    4'h6
`define ODRD_M_APSO    4'h7
`define ODRD_M_WDISP   4'h8
`define ODRD_M_WDEF    4'h9
`define ODRD_M_HDISP   4'ha
`define ODRD_M_HDEF    4'hb
`define ODRD_M_BDISP   4'hc
`define ODRD_M_BDEF    4'hd
`define ODRD_M_EXP     4'he

// framing limit, register reset word and stack word step
`define ODRD_MAX_OPND  3'h4
`define ODRD_RST_WORD  32'h0000_0000
`define ODRD_WORD_STEP 32'h0000_0004

`endif

// [core/odrd_pkg.sv]
package odrd_pkg;
    // decode state for the byte-serial instruction stream
    typedef enum logic [2:0] {
        ODRD_ST_OPC1,
        ODRD_ST_OPC2,
        ODRD_ST_DESC,
        ODRD_ST_EXT
    } odrd_state_t;

    // execution level of the processor
    typedef enum logic [1:0] {
        ODRD_LVL_KERNEL,
        ODRD_LVL_EXEC,
        ODRD_LVL_SUPV,
        ODRD_LVL_USER
    } odrd_level_t;

    // implicit pointer update issued by calls and returns
    typedef enum logic [1:0] {
        ODRD_PTR_NONE,
        ODRD_PTR_CALL,
        ODRD_PTR_RET
    } odrd_ptr_op_t;
endpackage

// [core/odrd_decode.sv]
`timescale 1ns/1ps
// Behaviour
// RULE1: descriptor bytes 5b ab bb cb db are format 2, all others format 1
// RULE2: low nibble of descriptor is register selector 0..15
// RULE3: high nibble of descriptor is mode selector 0..15
// RULE4: opcode is one or two bytes, then zero to four operand specifiers
// RULE5: each specifier is descriptor plus zero to four extension bytes
// RULE6: operands use descriptors unless the instruction locates them itself; code still consumes a descriptor byte for implied slots, with o_desc_vld low
// RULE7: thirty-two 32-bit registers usable as operands or address bases
// RULE8: r0-r8 and r16-r23 are plain general-purpose storage
// RULE9: r9 frame, r10 argument, r12 stack pointer; calls update them
// RULE10: stack pointer addresses next free word, stack grows upward
// RULE11: r11 status word, r13 control block, r14 interrupt stack, r15 pc
// RULE12: r11 r13 r14 r24-r31 writable only in kernel, else exception
// RULE13: status word has read-only fields and special flag handling
// RULE14: status word is an operand only in register mode
// RULE15: pc explicit only in displacement modes; implicit in control flow
// RULE16: block and string instructions use r0-r2 as implied arguments
// RULE17: bit-field operations act on one to thirty-two contiguous bits
// RULE18: legacy register selector 15 switches modes to immediate/absolute
// RULE19: class, mode and register presented in the descriptor's cycle
`include "odrd_regs.svh"

module odrd_decode #(
    parameter int          N_REGS    = 32,
    parameter int          W         = 32,
    parameter logic [W-1:0] PSW_RO_MASK = 32'hffff_0000,
    parameter logic [W-1:0] PSW_FLAG_MASK = 32'h0000_000f
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_byte_vld,
    input  wire logic [7:0]           i_byte,
    input  wire logic                 i_opc_two,
    input  wire logic [2:0]           i_opnd_cnt,
    input  wire logic [3:0]           i_implied_mask,
    input  wire odrd_pkg::odrd_level_t i_level,
    input  wire logic                 i_wr_en,
    input  wire logic [4:0]           i_wr_sel,
    input  wire logic [W-1:0]         i_wr_data,
    input  wire logic                 i_flag_wr,
    input  wire logic [W-1:0]         i_flag_data,
    input  wire logic [4:0]           i_rd_sel,
    input  wire odrd_pkg::odrd_ptr_op_t i_ptr_op,
    input  wire logic [W-1:0]         i_new_fp,
    input  wire logic [W-1:0]         i_new_ap,
    input  wire logic                 i_pc_ld,
    input  wire logic [W-1:0]         i_pc_data,
    input  wire logic                 i_block_op,
    input  wire logic [W-1:0]         i_blk_r0,
    input  wire logic [W-1:0]         i_blk_r1,
    input  wire logic [W-1:0]         i_blk_r2,
    input  wire logic [4:0]           i_bf_width,
    input  wire logic [4:0]           i_bf_off,
    output logic                      o_desc_vld,
    output logic                      o_fmt2,
    output logic [3:0]                o_mode,
    output logic [3:0]                o_reg_sel,
    output logic                      o_special,
    output logic [2:0]                o_ext_len,
    output logic                      o_invalid_desc,
    output logic                      o_opc_vld,
    output logic                      o_insn_done,
    output logic [W-1:0]              o_rd_data,
    output logic [W-1:0]              o_bf_mask,
    output logic                      o_priv_exc
);
    import odrd_pkg::*;

    //------------------------------------------------------------
    // helper functions
    //------------------------------------------------------------
    // format 2 class test
    function automatic logic is_fmt2(input logic [7:0] b);
        is_fmt2 = (b == `ODRD_F2_A) || (b == `ODRD_F2_B) ||
                  (b == `ODRD_F2_C) || (b == `ODRD_F2_D) ||
                  (b == `ODRD_F2_E);
    endfunction

    // extension byte count of a format 1 descriptor
    function automatic logic [2:0] ext_bytes(input logic [3:0] m,
                                             input logic [3:0] r);
        logic pc;
        pc = (r == `ODRD_REG_SEL_PC);
        case (m)
            `ODRD_M_REG:    ext_bytes = pc ? 3'h4 : 3'h0;
            `ODRD_M_REGDEF: ext_bytes = pc ? 3'h2 : 3'h0;
            `ODRD_M_FPSO:   ext_bytes = pc ? 3'h1 : 3'h0;
            `ODRD_M_APSO:   ext_bytes = pc ? 3'h4 : 3'h0;
            `ODRD_M_WDISP,
            `ODRD_M_WDEF:   ext_bytes = 3'h4;
            `ODRD_M_HDISP,
            `ODRD_M_HDEF:   ext_bytes = 3'h2;
            `ODRD_M_BDISP,
            `ODRD_M_BDEF:   ext_bytes = 3'h1;
            `ODRD_M_EXP:    ext_bytes = pc ? 3'h4 : 3'h0;
            default:        ext_bytes = 3'h0;
        endcase
    endfunction

    // privileged register test
    function automatic logic is_priv(input logic [4:0] s);
        is_priv = (s == `ODRD_R_PSW) || (s == `ODRD_R_PCBP) ||
                  (s == `ODRD_R_ISP) || (s >= `ODRD_R_PRIV_LO);
    endfunction

    //------------------------------------------------------------
    // descriptor field split
    //------------------------------------------------------------
    logic [3:0] reg_f;
    logic [3:0] mode_f;
    logic       f2;
    logic       disp_mode;
    assign reg_f  = i_byte[`ODRD_REG_LSB +: `ODRD_NIB_W];   // RULE2
    assign mode_f = i_byte[`ODRD_MODE_LSB +: `ODRD_NIB_W];  // RULE3
    assign f2     = is_fmt2(i_byte);                        // RULE1
    assign disp_mode = (mode_f >= `ODRD_M_WDISP) &&
                       (mode_f <= `ODRD_M_BDEF);

    //------------------------------------------------------------
    // instruction framing state
    //------------------------------------------------------------
    odrd_state_t st_r, st_nxt;
    logic [2:0]  opnd_left_r, opnd_left_nxt;
    logic [2:0]  ext_left_r, ext_left_nxt;
    logic [2:0]  opnd_idx_r, opnd_idx_nxt;
    logic [2:0]  req_cnt;
    logic        in_desc;
    logic        is_implied;

    // cap operand count at four
    assign req_cnt = (i_opnd_cnt > `ODRD_MAX_OPND) ? `ODRD_MAX_OPND
                                                   : i_opnd_cnt;  // RULE4
    assign in_desc = i_byte_vld && (st_r == ODRD_ST_DESC);
    assign is_implied = i_implied_mask[opnd_idx_r[1:0]];         // RULE6

    // next framing state
    always_comb begin
        st_nxt        = st_r;
        opnd_left_nxt = opnd_left_r;
        ext_left_nxt  = ext_left_r;
        opnd_idx_nxt  = opnd_idx_r;
        o_opc_vld     = 1'b0;
        o_insn_done   = 1'b0;
        if (i_byte_vld) begin
            case (st_r)
                ODRD_ST_OPC1: begin
                    o_opc_vld     = 1'b1;
                    opnd_left_nxt = req_cnt;
                    opnd_idx_nxt  = 3'h0;
                    if (i_opc_two) begin
                        st_nxt = ODRD_ST_OPC2;                    // RULE4
                    end else if (req_cnt == 3'h0) begin
                        o_insn_done = 1'b1;
                    end else begin
                        st_nxt = ODRD_ST_DESC;
                    end
                end
                ODRD_ST_OPC2: begin
                    if (opnd_left_r == 3'h0) begin
                        o_insn_done = 1'b1;
                        st_nxt      = ODRD_ST_OPC1;
                    end else begin
                        st_nxt = ODRD_ST_DESC;
                    end
                end
                ODRD_ST_DESC: begin
                    ext_left_nxt  = f2 ? 3'h0 : ext_bytes(mode_f, reg_f);
                    opnd_left_nxt = opnd_left_r - 3'h1;
                    opnd_idx_nxt  = opnd_idx_r + 3'h1;
                    if (ext_left_nxt != 3'h0) begin
                        st_nxt = ODRD_ST_EXT;                     // RULE5
                    end else if (opnd_left_nxt == 3'h0) begin
                        o_insn_done = 1'b1;
                        st_nxt      = ODRD_ST_OPC1;
                    end
                end
                ODRD_ST_EXT: begin
                    ext_left_nxt = ext_left_r - 3'h1;
                    if (ext_left_nxt == 3'h0) begin
                        if (opnd_left_r == 3'h0) begin
                            o_insn_done = 1'b1;
                            st_nxt      = ODRD_ST_OPC1;
                        end else begin
                            st_nxt = ODRD_ST_DESC;
                        end
                    end
                end
                default: st_nxt = ODRD_ST_OPC1;
            endcase
        end
    end

    // framing registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r        <= ODRD_ST_OPC1;
            opnd_left_r <= 3'h0;
            ext_left_r  <= 3'h0;
            opnd_idx_r  <= 3'h0;
        end else begin
            st_r        <= st_nxt;
            opnd_left_r <= opnd_left_nxt;
            ext_left_r  <= ext_left_nxt;
            opnd_idx_r  <= opnd_idx_nxt;
        end
    end

    //------------------------------------------------------------
    // descriptor presentation, same cycle as consumption
    //------------------------------------------------------------
    always_comb begin
        o_desc_vld     = in_desc && !is_implied;                  // RULE19
        o_fmt2         = f2;
        o_mode         = mode_f;
        o_reg_sel      = reg_f;
        o_special      = !f2 && (reg_f == `ODRD_REG_SEL_PC) &&
                         (mode_f >= `ODRD_M_REG) &&
                         (mode_f <= `ODRD_M_EXP) && !disp_mode;   // RULE18
        o_ext_len      = f2 ? 3'h0 : ext_bytes(mode_f, reg_f);
        o_invalid_desc = 1'b0;
        if (o_desc_vld && !f2) begin
            // status word as displacement base; short offsets hold no reg
            if (({1'b0, reg_f} == `ODRD_R_PSW) && disp_mode)      // RULE14
                o_invalid_desc = 1'b1;
            // pc explicit only in displacement modes, literals exempt
            if (({1'b0, reg_f} == `ODRD_R_PC) && !disp_mode &&
                !o_special && (mode_f >= `ODRD_M_REG) &&
                (mode_f <= `ODRD_M_EXP))                          // RULE15
                o_invalid_desc = 1'b1;
        end
    end

    //------------------------------------------------------------
    // register file
    //------------------------------------------------------------
    logic [W-1:0] rf_r   [N_REGS];                                // RULE7
    logic [W-1:0] rf_nxt [N_REGS];
    logic         wr_ok;

    assign wr_ok      = i_wr_en && (!is_priv(i_wr_sel) ||
                        (i_level == ODRD_LVL_KERNEL));            // RULE12
    assign o_priv_exc = i_wr_en && !wr_ok;                        // RULE12

    // next register contents
    always_comb begin
        for (int k = 0; k < N_REGS; k++) rf_nxt[k] = rf_r[k];     // RULE8
        if (wr_ok) begin
            if (i_wr_sel == `ODRD_R_PSW)                          // RULE13
                rf_nxt[`ODRD_R_PSW] = (rf_r[`ODRD_R_PSW] & PSW_RO_MASK)
                                    | (i_wr_data & ~PSW_RO_MASK);
            else
                rf_nxt[i_wr_sel] = i_wr_data;                     // RULE11
        end
        if (i_flag_wr)                                            // RULE13
            rf_nxt[`ODRD_R_PSW] = (rf_nxt[`ODRD_R_PSW] & ~PSW_FLAG_MASK)
                                | (i_flag_data & PSW_FLAG_MASK);
        if (i_block_op) begin                                     // RULE16
            rf_nxt[0] = i_blk_r0;
            rf_nxt[1] = i_blk_r1;
            rf_nxt[2] = i_blk_r2;
        end
        case (i_ptr_op)                                           // RULE9
            ODRD_PTR_CALL: begin
                rf_nxt[`ODRD_R_AP] = i_new_ap;
                rf_nxt[`ODRD_R_FP] = rf_r[`ODRD_R_SP];
                rf_nxt[`ODRD_R_SP] = rf_r[`ODRD_R_SP]
                                   + `ODRD_WORD_STEP;             // RULE10
            end
            ODRD_PTR_RET: begin
                rf_nxt[`ODRD_R_SP] = rf_r[`ODRD_R_AP];
                rf_nxt[`ODRD_R_FP] = i_new_fp;
                rf_nxt[`ODRD_R_AP] = i_new_ap;
            end
            default: ;
        endcase
        if (i_pc_ld) rf_nxt[`ODRD_R_PC] = i_pc_data;              // RULE15
    end

    // register storage
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < N_REGS; k++) rf_r[k] <= `ODRD_RST_WORD;
        end else begin
            for (int k = 0; k < N_REGS; k++) rf_r[k] <= rf_nxt[k];
        end
    end

    //------------------------------------------------------------
    // read port and bit-field mask
    //------------------------------------------------------------
    logic [W-1:0] rd_nxt, rd_r;
    logic [W-1:0] bf_nxt, bf_r;
    logic [5:0]   bf_len;

    // width code 0..31 means one to thirty-two bits
    always_comb begin
        bf_len = {1'b0, i_bf_width} + 6'h01;                      // RULE17
        rd_nxt = rf_r[i_rd_sel];
        bf_nxt = ((bf_len == 6'h20) ? {W{1'b1}}
                 : ((W'(1) << bf_len[4:0]) - W'(1))) << i_bf_off;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_r <= `ODRD_RST_WORD;
            bf_r <= `ODRD_RST_WORD;
        end else begin
            rd_r <= rd_nxt;
            bf_r <= bf_nxt;
        end
    end

    assign o_rd_data = rd_r;
    assign o_bf_mask = bf_r;
endmodule // odrd_decode

// [tb/odrd_decode_assertions.sv]
`timescale 1ns/1ps
`include "odrd_regs.svh"
module odrd_decode_assertions (
    input wire logic                  i_mclk,
    input wire logic                  i_rst_n,
    input wire logic                  i_byte_vld,
    input wire logic [7:0]            i_byte,
    input wire odrd_pkg::odrd_level_t i_level,
    input wire logic                  i_wr_en,
    input wire logic [4:0]            i_wr_sel,
    input wire logic [31:0]           i_wr_data,
    input wire logic [4:0]            i_rd_sel,
    input wire logic                  o_desc_vld,
    input wire logic                  o_fmt2,
    input wire logic [3:0]            o_mode,
    input wire logic [3:0]            o_reg_sel,
    input wire logic [2:0]            o_ext_len,
    input wire logic                  o_insn_done,
    input wire logic [31:0]           o_rd_data,
    input wire logic                  o_priv_exc
);
    import odrd_pkg::*;
    // ----------------
    // helper terms
    // ----------------
    logic priv_sel;
    logic gp_wr;
    // privileged targets and allowed plain writes
    assign priv_sel = i_wr_sel inside {5'h0b, 5'h0d, 5'h0e} ||
                      i_wr_sel >= 5'h18;
    assign gp_wr = i_wr_en && (!priv_sel || i_level == ODRD_LVL_KERNEL) &&
                   (i_wr_sel inside {[5'h03:5'h08]} || i_wr_sel >= 5'h10);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    // ----------------
    // properties
    // ----------------
    AST_FMT2_CLASS: assert property (o_desc_vld |->
        o_fmt2 == (i_byte inside {`ODRD_F2_A, `ODRD_F2_B, `ODRD_F2_C,
                                  `ODRD_F2_D, `ODRD_F2_E}))
        else $error("format class wrong");
    AST_REG_FIELD: assert property (o_desc_vld |->
        o_reg_sel == i_byte[3:0])
        else $error("register field wrong");
    AST_MODE_FIELD: assert property (o_desc_vld |->
        o_mode == i_byte[7:4])
        else $error("mode field wrong");
    AST_DESC_CYCLE: assert property (o_desc_vld |-> i_byte_vld)
        else $error("descriptor shown without a byte");
    AST_PRIV_EXC: assert property (i_wr_en && i_level != ODRD_LVL_KERNEL
        && priv_sel |-> o_priv_exc)
        else $error("privileged write not flagged");
    AST_KERNEL_FREE: assert property (i_level == ODRD_LVL_KERNEL |->
        !o_priv_exc)
        else $error("exception at kernel level");
    AST_WORD_DISP: assert property (o_desc_vld && !o_fmt2 &&
        i_byte[7:5] == 3'h4 && i_byte[3:0] != 4'hb |-> o_ext_len == 3'h4)
        else $error("word displacement length wrong");
    AST_WORD_IMM: assert property (o_desc_vld && i_byte == 8'h4f |->
        o_ext_len == 3'h4)
        else $error("word immediate length wrong");
    AST_RD_BACK: assert property (gp_wr ##2
        (i_rd_sel == $past(i_wr_sel, 2) && !$past(i_wr_en) && !i_wr_en)
        |=> o_rd_data == $past(i_wr_data, 3))
        else $error("register read back wrong");
    // main scenarios seen
    COV_FMT2: cover property (o_desc_vld && o_fmt2);
    COV_PRIV: cover property (o_priv_exc);
    COV_DONE: cover property (o_desc_vld && o_insn_done);
endmodule // odrd_decode_assertions

bind odrd_decode odrd_decode_assertions u_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_byte_vld(i_byte_vld),
    .i_byte(i_byte), .i_level(i_level), .i_wr_en(i_wr_en),
    .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data), .i_rd_sel(i_rd_sel),
    .o_desc_vld(o_desc_vld), .o_fmt2(o_fmt2), .o_mode(o_mode),
    .o_reg_sel(o_reg_sel), .o_ext_len(o_ext_len), .o_insn_done(o_insn_done),
    .o_rd_data(o_rd_data), .o_priv_exc(o_priv_exc)
);

// [tb/tb.sv]
`timescale 1ns/1ps
`include "odrd_regs.svh"
module tb;
    import odrd_pkg::*;
    `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
        error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
    // ----------------
    // stimulus and outputs
    // ----------------
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_byte_vld = 1'b0, i_opc_two = 1'b0;
    logic i_wr_en = 1'b0, i_flag_wr = 1'b0, i_pc_ld = 1'b0, i_block_op = 1'b0;
    logic [7:0]   i_byte = 8'h00;
    logic [2:0]   i_opnd_cnt = 3'h0;
    logic [3:0]   i_implied_mask = 4'h0;
    logic [4:0]   i_wr_sel = 5'h00, i_rd_sel = 5'h00;
    logic [4:0]   i_bf_width = 5'h00, i_bf_off = 5'h00;
    logic [31:0]  i_wr_data = 32'h0, i_flag_data = 32'h0, i_pc_data = 32'h0;
    logic [31:0]  i_new_fp = 32'h0, i_new_ap = 32'h0, i_blk_r0 = 32'h0;
    logic [31:0]  i_blk_r1 = 32'h0, i_blk_r2 = 32'h0;
    odrd_level_t  i_level = ODRD_LVL_KERNEL;
    odrd_ptr_op_t i_ptr_op = ODRD_PTR_NONE;
    logic o_desc_vld, o_fmt2, o_special, o_invalid_desc, o_opc_vld;
    logic o_insn_done, o_priv_exc;
    logic [3:0]   o_mode, o_reg_sel;
    logic [2:0]   o_ext_len;
    logic [31:0]  o_rd_data, o_bf_mask;
    int           error_cnt = 0, tests_run = 0;

    odrd_decode DUT (.i_mclk, .i_rst_n, .i_byte_vld, .i_byte, .i_opc_two,
        .i_opnd_cnt, .i_implied_mask, .i_level, .i_wr_en, .i_wr_sel,
        .i_wr_data, .i_flag_wr, .i_flag_data, .i_rd_sel, .i_ptr_op,
        .i_new_fp, .i_new_ap, .i_pc_ld, .i_pc_data, .i_block_op, .i_blk_r0,
        .i_blk_r1, .i_blk_r2, .i_bf_width, .i_bf_off, .o_desc_vld, .o_fmt2,
        .o_mode, .o_reg_sel, .o_special, .o_ext_len, .o_invalid_desc,
        .o_opc_vld, .o_insn_done, .o_rd_data, .o_bf_mask, .o_priv_exc);

    // free-running clock
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end
    // ----------------
    // helpers
    // ----------------
    function automatic int ext_of(logic [7:0] d);
        if (d inside {8'h5b, 8'hab, 8'hbb, 8'hcb, 8'hdb}) return 0;
        case (d[7:4])
            4'h4, 4'h7, 4'he: return (d[3:0] == 4'hf) ? 4 : 0;
            4'h5: return (d[3:0] == 4'hf) ? 2 : 0;
            4'h6: return (d[3:0] == 4'hf) ? 1 : 0;
            4'h8, 4'h9: return 4;
            4'ha, 4'hb: return 2;
            4'hc, 4'hd: return 1;
            default: return 0;
        endcase
    endfunction
    task automatic sb(logic [7:0] b);
        @(posedge i_mclk);
        i_byte <= b;
        i_byte_vld <= 1'b1;
        @(negedge i_mclk);
    endtask
    task automatic opc(logic two, logic [2:0] n, logic [3:0] m);
        @(posedge i_mclk);
        i_byte <= 8'h10;
        i_byte_vld <= 1'b1;
        i_opc_two <= two;
        i_opnd_cnt <= n;
        i_implied_mask <= m;
        @(negedge i_mclk);
        `CHK(o_opc_vld, 1'b1);
    endtask
    task automatic idle();
        @(posedge i_mclk);
        i_byte_vld <= 1'b0;
    endtask
    task automatic wr(logic [4:0] s, logic [31:0] v, odrd_level_t l, logic x);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_wr_sel <= s;
        i_wr_data <= v;
        i_level <= l;
        @(negedge i_mclk);
        `CHK(o_priv_exc, x);
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
        i_level <= ODRD_LVL_KERNEL;
    endtask
    task automatic rd(logic [4:0] s, logic [31:0] v);
        @(posedge i_mclk);
        i_rd_sel <= s;
        @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK(o_rd_data, v);
    endtask
    task automatic bf(logic [4:0] w, logic [4:0] o, logic [31:0] e);
        @(posedge i_mclk);
        i_bf_width <= w;
        i_bf_off <= o;
        @(posedge i_mclk);
        @(negedge i_mclk);
        `CHK(o_bf_mask, e);
    endtask
    task automatic do_reset();
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        i_byte_vld <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_desc();
        int   n;
        logic f2e;
        logic alt;
        for (int d = 0; d < 256; d++) begin
            if ((d[7:4] == 4'he && d[3:0] != 4'hf) ||
                d == 8'h8b || d == 8'h9b)
                continue;
            n = ext_of(d[7:0]);
            f2e = d[7:0] inside {8'h5b, 8'hab, 8'hbb, 8'hcb, 8'hdb};
            alt = d[3:0] == 4'hf &&
                  d[7:4] inside {4'h4, 4'h5, 4'h6, 4'h7, 4'he};
            opc(1'b0, 3'h1, 4'h0);
            sb(d[7:0]);
            `CHK(o_desc_vld, 1'b1);
            `CHK(o_fmt2, f2e);
            `CHK(o_special, alt);
            `CHK(o_invalid_desc, 1'b0);
            `CHK(o_mode, d[7:4]);
            `CHK(o_reg_sel, d[3:0]);
            `CHK(o_ext_len, n[2:0]);
            for (int k = 0; k < n; k++) begin
                sb(8'h5b);
                `CHK(o_desc_vld, 1'b0);
            end
            `CHK(o_insn_done, 1'b1);
        end
        idle();
        $display("descriptor sweep done");
    endtask
    task automatic t_frame();
        opc(1'b1, 3'h4, 4'b0010);
        sb(8'h99);
        `CHK(o_desc_vld, 1'b0);
        sb(8'h41);
        `CHK(o_insn_done, 1'b0);
        sb(8'hc2);
        `CHK(o_desc_vld, 1'b0);
        sb(8'h7f);
        sb(8'h13);
        `CHK(o_insn_done, 1'b0);
        sb(8'h27);
        `CHK(o_insn_done, 1'b1);
        opc(1'b0, 3'h0, 4'h0);
        `CHK(o_insn_done, 1'b1);
        opc(1'b0, 3'h1, 4'h0);
        sb(8'h4b);
        `CHK(o_invalid_desc, 1'b0);
        opc(1'b0, 3'h1, 4'h0);
        sb(8'h9b);
        `CHK(o_invalid_desc, 1'b1);
        do_reset();
        opc(1'b0, 3'h0, 4'h0);
        idle();
        $display("framing done");
    endtask
    task automatic t_regs();
        logic [4:0] pl [5] = '{5'h0b, 5'h0d, 5'h0e, 5'h18, 5'h1f};
        for (int s = 0; s < 32; s++)
            if (s != 11 && s != 15) wr(s[4:0], {16'hc0de, 11'h0, s[4:0]},
                                       ODRD_LVL_KERNEL, 1'b0);
        for (int s = 0; s < 32; s++)
            if (s != 11 && s != 15)
                rd(s[4:0], {16'hc0de, 11'h0, s[4:0]});
        for (int l = 1; l < 4; l++)
            foreach (pl[k]) begin
                wr(pl[k], 32'hdead0000, odrd_level_t'(l), 1'b1);
                rd(pl[k], pl[k] == 5'h0b ? 32'h0
                                         : {16'hc0de, 11'h0, pl[k]});
            end
        wr(5'h05, 32'h00000055, ODRD_LVL_USER, 1'b0);
        rd(5'h05, 32'h00000055);
        wr(5'h0b, 32'hffffffff, ODRD_LVL_KERNEL, 1'b0);
        rd(5'h0b, 32'h0000ffff);
        @(posedge i_mclk);
        i_flag_wr <= 1'b1;
        @(posedge i_mclk);
        i_flag_wr <= 1'b0;
        rd(5'h0b, 32'h0000fff0);
        $display("register file done");
    endtask
    task automatic t_ptrs();
        wr(5'h0c, 32'h00001000, ODRD_LVL_KERNEL, 1'b0);
        @(posedge i_mclk);
        i_ptr_op <= ODRD_PTR_CALL;
        i_new_ap <= 32'h00002000;
        @(posedge i_mclk);
        i_ptr_op <= ODRD_PTR_NONE;
        rd(5'h09, 32'h00001000);
        rd(5'h0a, 32'h00002000);
        rd(5'h0c, 32'h00001004);
        @(posedge i_mclk);
        i_ptr_op <= ODRD_PTR_RET;
        i_new_fp <= 32'h00003000;
        i_new_ap <= 32'h00004000;
        @(posedge i_mclk);
        i_ptr_op <= ODRD_PTR_NONE;
        rd(5'h0c, 32'h00002000);
        rd(5'h09, 32'h00003000);
        @(posedge i_mclk);
        i_block_op <= 1'b1;
        i_blk_r0 <= 32'h000000a0;
        i_blk_r1 <= 32'h000000a1;
        i_blk_r2 <= 32'h000000a2;
        i_pc_ld <= 1'b1;
        i_pc_data <= 32'h00008000;
        @(posedge i_mclk);
        i_block_op <= 1'b0;
        i_pc_ld <= 1'b0;
        rd(5'h00, 32'h000000a0);
        rd(5'h02, 32'h000000a2);
        rd(5'h0f, 32'h00008000);
        bf(5'h00, 5'h00, 32'h00000001);
        bf(5'h1f, 5'h00, 32'hffffffff);
        bf(5'h03, 5'h04, 32'h000000f0);
        bf(5'h00, 5'h1f, 32'h80000000);
        $display("pointers and fields done");
    endtask
    task automatic results();
        $display("tests %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_desc();
        t_frame();
        t_regs();
        t_ptrs();
        results();
    end
    // hang guard, well past the expected run
    initial begin
        #400000;
        error_cnt++;
        results();
    end
endmodule // tb
